// >>> verilog/serdes_link_pkg.sv
// constants, types and register map of the serdes link lock control block
`default_nettype none
package serdes_link_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned LINK_BIT_NS       = 160;
  localparam int unsigned TX_BIT_CYCLES     = LINK_BIT_NS / CLK_PERIOD_NS;
  localparam int unsigned REF_TIMEOUT_NS    = 2000;
  localparam int unsigned REF_TIMEOUT_CYC   = REF_TIMEOUT_NS / CLK_PERIOD_NS;
  // ==========================================================
  // framing
  localparam int unsigned WORD_BITS         = 10;
  localparam int unsigned FRAME_BITS        = 12;
  localparam int unsigned LOSS_WORDS        = 4;
  localparam int unsigned LOCK_WORDS        = 4;
  localparam int unsigned TRAIN_MIN_SYMBOLS = 1024;
  localparam logic [9:0]  TRAINING_PATTERN  = 10'h01f;
  localparam logic        START_BIT         = 1'b1;
  localparam logic        STOP_BIT          = 1'b0;
  // ==========================================================
  // register map
  localparam logic [11:0] CTRL_OFS          = 12'h000;
  localparam logic [11:0] STATUS_OFS        = 12'h004;
  localparam logic [11:0] IRQ_STATUS_OFS    = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS      = 12'h00c;
  localparam logic [11:0] RX_WORD_OFS       = 12'h010;
  localparam logic [11:0] TX_WORD_OFS       = 12'h014;
  localparam int unsigned CTRL_TRAIN_POS    = 0;
  localparam int unsigned ST_LOCKED_POS     = 0;
  localparam int unsigned ST_TRAINING_POS   = 1;
  localparam int unsigned ST_REF_OK_POS     = 2;
  localparam int unsigned ST_DRIVEN_POS     = 3;
  localparam int unsigned IRQ_ACQ_POS       = 0;
  localparam int unsigned IRQ_LOSS_POS      = 1;
  localparam int unsigned IRQ_BAD_POS       = 2;
  localparam int unsigned IRQ_BITS          = 3;
  localparam logic        CTRL_TRAIN_RESET  = 1'b0;
  localparam logic [2:0]  IRQ_MASK_RESET    = 3'h0;
  localparam logic [9:0]  TX_WORD_RESET     = 10'h000;
  // ==========================================================
  // synchronised pins
  localparam int unsigned PIN_LINK_CLK      = 0;
  localparam int unsigned PIN_SERIAL        = 1;
  localparam int unsigned PIN_TRAIN_A       = 2;
  localparam int unsigned PIN_TRAIN_B       = 3;
  localparam int unsigned PIN_REF_CLK       = 4;
  localparam int unsigned PIN_OUT_EN        = 5;
  localparam int unsigned PIN_SLEEP_N       = 6;
  localparam int unsigned PIN_COUNT         = 7;
  // ==========================================================
  // types
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;
  typedef enum logic [2:0] {
    RX_HUNT    = 3'b001,
    RX_CONFIRM = 3'b010,
    RX_LOCKED  = 3'b100
  } rx_state_t;
endpackage
`default_nettype wire

// >>> verilog/serdes_link_lock_control.sv
// serializer framing/training and deserializer lock supervision with apb registers
// Notes on behaviour
// - the receiver checks each word's clock field and raises lock_n when lock is lost.
// - without a reference clock timeout or sleep, loss of lock needs four invalid clock fields in a row; fewer keep lock.
// - after power-up the parallel outputs float until activity is seen and lock is won.
// - the serializer sends training patterns while either training request is high.
// - lock_n is high from startup and falls only once the receiver has locked.
// - the receiver also locks to plain random data without training patterns.
// - while lock_n is low the parallel outputs carry every received word, including words with bad clock fields.
// - relock comes from renewed training or from random-data acquisition.
// - each ten-bit word is framed by a start and a stop clock bit on the serial line.
// - a training request yields at least 1024 training words, more while it stays high.
// - output enable low floats the parallel word and the recovered clock outputs.
`default_nettype none
module serdes_link_lock_control #(
  parameter int unsigned TRAIN_MIN   = serdes_link_pkg::TRAIN_MIN_SYMBOLS,
  parameter int unsigned LOCK_RUN    = serdes_link_pkg::LOCK_WORDS,
  parameter int unsigned LOSS_RUN    = serdes_link_pkg::LOSS_WORDS,
  parameter int unsigned REF_TIMEOUT = serdes_link_pkg::REF_TIMEOUT_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire serdes_link_pkg::apb_req_t apb_req,
  output var  serdes_link_pkg::apb_rsp_t apb_rsp,
  output logic                           irq,
  input  wire logic                      training_request_a,
  input  wire logic                      training_request_b,
  input  wire logic                      local_reference_clock,
  input  wire logic                      sleep_request_n,
  input  wire logic                      out_enable,
  output logic                           serial_out,
  output logic                           tx_link_clk,
  input  wire logic                      serial_in,
  input  wire logic                      rx_link_clk,
  output logic                           lock_n,
  output logic [9:0]                     parallel_word_out,
  output logic                           parallel_word_oe_n,
  output logic                           recovered_clock,
  output logic                           recovered_clock_oe_n
);
  import serdes_link_pkg::*;

  localparam int unsigned TW = $clog2(TRAIN_MIN + 1);
  localparam int unsigned RW = $clog2(REF_TIMEOUT + 1);
  localparam logic [TW-1:0] TRAIN_LOAD = TW'(TRAIN_MIN - 1);
  localparam logic [RW-1:0] REF_MAX    = RW'(REF_TIMEOUT);
  localparam logic [3:0]    FRAME_LAST = 4'(FRAME_BITS - 1);
  localparam logic [3:0]    FRAME_HALF = 4'(FRAME_BITS / 2);
  localparam logic [2:0]    DIV_LAST   = 3'(TX_BIT_CYCLES - 1);
  localparam logic [2:0]    DIV_HALF   = 3'(TX_BIT_CYCLES / 2);
  localparam logic [2:0]    LOCK_LAST  = 3'(LOCK_RUN - 1);
  localparam logic [2:0]    LOSS_LAST  = 3'(LOSS_RUN - 1);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ==========================================================
  // pin synchronisers: a change counts once stages two and three agree
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_f;
  logic [PIN_COUNT-1:0] pin_rise;
  assign pin_raw = {sleep_request_n, out_enable, local_reference_clock,
                    training_request_b, training_request_a, serial_in, rx_link_clk};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_sync
      logic [2:0] s_q;
      logic       f_q;
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s_q <= 3'h0;
          f_q <= 1'b0;
        end
        else
        begin
          s_q <= {s_q[1:0], pin_raw[gi]};
          if (s_q[1] == s_q[2])
            f_q <= s_q[2];
        end
      end
      assign pin_f[gi]    = f_q;
      assign pin_rise[gi] = (s_q[1] == s_q[2]) && s_q[2] && !f_q;
    end
  endgenerate

  // sleep forces both halves idle and restarts the power-up float
  wire awake   = pin_f[PIN_SLEEP_N];
  wire out_en  = pin_f[PIN_OUT_EN];
  wire bit_stb = pin_rise[PIN_LINK_CLK];
  wire bit_val = pin_rise[PIN_LINK_CLK] ? pin_f[PIN_SERIAL] : pin_f[PIN_SERIAL];

  // ==========================================================
  // reference clock activity; no lock is possible without it
  logic [RW-1:0] ref_cnt_q;
  wire ref_ok = (ref_cnt_q < REF_MAX);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ref_cnt_q <= REF_MAX;
    else if (pin_rise[PIN_REF_CLK])
      ref_cnt_q <= '0;
    else if (ref_ok)
      ref_cnt_q <= ref_cnt_q + 1'b1;
  end

  // ==========================================================
  // apb slave, zero wait states
  logic          ctrl_train_q;
  logic [IRQ_BITS-1:0] irq_stat_q;
  logic [IRQ_BITS-1:0] irq_mask_q;
  logic [9:0]    tx_word_q;
  logic [9:0]    rx_word_q;
  logic [31:0]   status_w;
  wire acc     = apb_req.psel && apb_req.penable;
  wire wr      = acc && apb_req.pwrite;
  wire a_ctrl  = hit(apb_req.paddr, CTRL_OFS);
  wire a_stat  = hit(apb_req.paddr, STATUS_OFS);
  wire a_istat = hit(apb_req.paddr, IRQ_STATUS_OFS);
  wire a_imask = hit(apb_req.paddr, IRQ_MASK_OFS);
  wire a_rx    = hit(apb_req.paddr, RX_WORD_OFS);
  wire a_tx    = hit(apb_req.paddr, TX_WORD_OFS);
  wire mapped  = a_ctrl | a_stat | a_istat | a_imask | a_rx | a_tx;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc && !mapped;
  assign apb_rsp.prdata  = a_ctrl  ? {31'h0, ctrl_train_q} :
                           a_stat  ? status_w :
                           a_istat ? {29'h0, irq_stat_q} :
                           a_imask ? {29'h0, irq_mask_q} :
                           a_rx    ? {22'h0, rx_word_q} :
                           a_tx    ? {22'h0, tx_word_q} : 32'h0;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_train_q <= CTRL_TRAIN_RESET;
      irq_mask_q   <= IRQ_MASK_RESET;
      tx_word_q    <= TX_WORD_RESET;
    end
    else if (wr)
    begin
      if (a_ctrl)
        ctrl_train_q <= apb_req.pwdata[CTRL_TRAIN_POS];
      if (a_imask)
        irq_mask_q <= apb_req.pwdata[IRQ_BITS-1:0];
      if (a_tx)
        tx_word_q <= apb_req.pwdata[9:0];
    end
  end

  // ==========================================================
  // serializer: bit divider, framing and training
  logic [2:0]     div_q;
  logic [3:0]     tbit_q;
  logic [11:0]    tx_sh_q;
  logic [TW-1:0]  train_left_q;
  logic           tx_training_q;
  logic           tx_clk_q;
  wire train_req  = pin_f[PIN_TRAIN_A] | pin_f[PIN_TRAIN_B] | ctrl_train_q;
  wire train_word = train_req || (train_left_q != '0);
  wire bit_end    = (div_q == DIV_LAST);
  wire tx_load    = awake && bit_end && (tbit_q == FRAME_LAST);
  wire [9:0] tx_payload = train_word ? TRAINING_PATTERN : tx_word_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_q         <= DIV_LAST;
      tbit_q        <= FRAME_LAST;
      tx_sh_q       <= 12'h000;
      train_left_q  <= '0;
      tx_training_q <= 1'b0;
      tx_clk_q      <= 1'b0;
    end
    else if (!awake)
    begin
      div_q    <= DIV_LAST;
      tbit_q   <= FRAME_LAST;
      tx_sh_q  <= 12'h000;
      tx_clk_q <= 1'b0;
    end
    else
    begin
      div_q    <= bit_end ? 3'h0 : div_q + 1'b1;
      tx_clk_q <= !bit_end && (div_q + 1'b1 >= DIV_HALF);
      if (tx_load)
      begin
        tbit_q        <= 4'h0;
        tx_sh_q       <= {START_BIT, tx_payload, STOP_BIT};
        tx_training_q <= train_word;
        if (train_req)
          train_left_q <= TRAIN_LOAD;
        else if (train_left_q != '0)
          train_left_q <= train_left_q - 1'b1;
      end
      else if (bit_end)
      begin
        tbit_q  <= tbit_q + 1'b1;
        tx_sh_q <= {tx_sh_q[10:0], 1'b0};
      end
    end
  end
  assign serial_out  = tx_sh_q[11];
  assign tx_link_clk = tx_clk_q;

  // ==========================================================
  // deserializer: hunt any bit offset, confirm, then supervise lock
  rx_state_t   st_q, st_d;
  logic [11:0] sh_q;
  logic [3:0]  rbit_q, rbit_d;
  logic [2:0]  good_q, good_d, bad_q, bad_d;
  logic        word_ld, ev_acq, ev_loss, ev_bad;
  logic        seen_lock_q, lock_n_q, rclk_q, drive_q, rclk_drive_q;
  wire [11:0] sh_d   = bit_stb ? {sh_q[10:0], bit_val} : sh_q;
  wire frame_ok      = (sh_d[11] == START_BIT) && (sh_d[0] == STOP_BIT);
  wire frame_end     = bit_stb && (rbit_q == FRAME_LAST);
  wire can_lock      = awake && ref_ok;
  always_comb
  begin
    st_d    = st_q;
    rbit_d  = rbit_q;
    good_d  = good_q;
    bad_d   = bad_q;
    word_ld = 1'b0;
    ev_acq  = 1'b0;
    ev_loss = 1'b0;
    ev_bad  = 1'b0;
    if (bit_stb)
      rbit_d = (rbit_q == FRAME_LAST) ? 4'h0 : rbit_q + 1'b1;
    if (!can_lock)
    begin
      st_d    = RX_HUNT;
      ev_loss = (st_q == RX_LOCKED);
    end
    else
    begin
      case (st_q)
        RX_HUNT:
          // random data and training both lock here, one bit offset at a time
          if (bit_stb && frame_ok)
          begin
            st_d   = RX_CONFIRM;
            rbit_d = 4'h0;
            good_d = 3'h1;
          end
        RX_CONFIRM:
          if (frame_end)
          begin
            if (!frame_ok)
              st_d = RX_HUNT;
            else if (good_q == LOCK_LAST)
            begin
              st_d    = RX_LOCKED;
              ev_acq  = 1'b1;
              word_ld = 1'b1;
              bad_d   = 3'h0;
            end
            else
              good_d = good_q + 1'b1;
          end
        RX_LOCKED:
          if (frame_end)
          begin
            // words around a loss may be corrupt; the far side discards them
            word_ld = 1'b1;
            if (frame_ok)
              bad_d = 3'h0;
            else
            begin
              ev_bad = 1'b1;
              if (bad_q == LOSS_LAST)
              begin
                st_d    = RX_HUNT;
                ev_loss = 1'b1;
              end
              else
                bad_d = bad_q + 1'b1;
            end
          end
        default:
          st_d = RX_HUNT;
      endcase
    end
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q   <= RX_HUNT;
      sh_q   <= 12'h000;
      rbit_q <= 4'h0;
      good_q <= 3'h0;
      bad_q  <= 3'h0;
    end
    else
    begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      rbit_q <= rbit_d;
      good_q <= good_d;
      bad_q  <= bad_d;
    end
  end

  // ==========================================================
  // receiver outputs, interrupts and status
  wire [IRQ_BITS-1:0] irq_set = {ev_bad, ev_loss, ev_acq};
  wire [IRQ_BITS-1:0] irq_clr = (wr && a_istat) ? apb_req.pwdata[IRQ_BITS-1:0] : '0;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_n_q     <= 1'b1;
      seen_lock_q  <= 1'b0;
      rx_word_q    <= 10'h000;
      rclk_q       <= 1'b0;
      drive_q      <= 1'b0;
      rclk_drive_q <= 1'b0;
      irq_stat_q   <= '0;
    end
    else
    begin
      lock_n_q     <= (st_d != RX_LOCKED);
      seen_lock_q  <= awake && (seen_lock_q || st_d == RX_LOCKED);
      rclk_q       <= (st_d == RX_LOCKED) && (rbit_d < FRAME_HALF);
      drive_q      <= out_en && awake && (seen_lock_q || st_d == RX_LOCKED);
      rclk_drive_q <= out_en && awake;
      // set beats a simultaneous write-one clear
      irq_stat_q   <= irq_set | (irq_stat_q & ~irq_clr);
      if (word_ld)
        rx_word_q <= sh_d[10:1];
    end
  end
  assign lock_n               = lock_n_q;
  assign parallel_word_out    = rx_word_q;
  assign parallel_word_oe_n   = !drive_q;
  assign recovered_clock      = rclk_q;
  assign recovered_clock_oe_n = !rclk_drive_q;
  assign irq                  = |(irq_stat_q & irq_mask_q);
  assign status_w = {28'h0, drive_q, ref_ok, tx_training_q, !lock_n_q};

  // ==========================================================
  // checks
  sequence bad_frame_s;
    (st_q == RX_LOCKED) && ev_bad && can_lock;
  endsequence
  sequence acquire_s;
    (st_q == RX_CONFIRM) ##1 (st_q == RX_LOCKED);
  endsequence

  lock_drop_a: assert property (ev_loss |=> lock_n)
    else $error("lock_n not raised after loss");
  short_run_a: assert property (bad_frame_s and (bad_q < LOSS_LAST) |=> st_q == RX_LOCKED)
    else $error("lock dropped before four bad fields");
  fourth_bad_a: assert property (bad_frame_s and (bad_q == LOSS_LAST) |=> st_q == RX_HUNT ##1 lock_n)
    else $error("lock kept after four bad fields");
  float_before_a: assert property (!seen_lock_q && (st_d != RX_LOCKED) |=> parallel_word_oe_n)
    else $error("outputs driven before first lock");
  train_or_a: assert property (tx_load && (pin_f[PIN_TRAIN_A] || pin_f[PIN_TRAIN_B]) |=> tx_sh_q[10:1] == TRAINING_PATTERN)
    else $error("training request ignored");
  lock_fall_a: assert property ($fell(lock_n) |-> $past(st_q) == RX_CONFIRM)
    else $error("lock_n fell without acquisition");
  acq_low_a: assert property (acquire_s |-> !lock_n)
    else $error("lock_n high after acquisition");
  frame_bits_a: assert property (tx_load |=> tx_sh_q[11] == START_BIT && tx_sh_q[0] == STOP_BIT)
    else $error("frame clock bits wrong");
  train_hold_a: assert property (tx_load && train_left_q != '0 |=> tx_training_q)
    else $error("training ended early");
  out_float_a: assert property (!out_en |=> parallel_word_oe_n && recovered_clock_oe_n)
    else $error("outputs driven with enable low");
  word_valid_a: assert property ((st_q == RX_LOCKED) && frame_end && frame_ok && can_lock |=> parallel_word_out == $past(sh_d[10:1]))
    else $error("received word not presented");
  hunt_reject_a: assert property ((st_q == RX_HUNT) && bit_stb && !frame_ok |=> st_q == RX_HUNT)
    else $error("bad clock field accepted in hunt");
endmodule // serdes_link_lock_control
`default_nettype wire

// >>> verif/serdes_far_tx_model.sv
// behavioural far-end serializer that feeds the receiver half
`default_nettype none
module serdes_far_tx_model
  import serdes_link_pkg::*;
(
  input  wire logic        en,
  input  wire logic [9:0]  word,
  input  wire logic        bad,
  output logic             ser,
  output logic             lclk,
  output logic [15:0]      frames
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] f;
  // ==========================================
  // frame generator
  initial
  begin
    ser = 1'b0;
    lclk = 1'b0;
    frames = '0;
    #7;
    forever
    begin
      if (!en)
      begin
        // clock stands still, line wanders so stale data never looks valid
        lclk = 1'b0;
        ser = ~ser;
        #80;
      end
      else
      begin
        // a bad frame swaps the two clock bits on purpose
        f = bad ? {STOP_BIT, word, START_BIT} : {START_BIT, word, STOP_BIT};
        for (int i = 11; i >= 0; i--)
        begin
          ser = f[i];
          lclk = 1'b0;
          #80;
          lclk = 1'b1;
          if (i == 0)
            frames = frames + 16'h1;
          #80;
        end
      end
    end
  end
endmodule // serdes_far_tx_model
`default_nettype wire

// >>> verif/serdes_link_lock_control_tb_top.sv
// self-checking bench for the serdes link lock control block
`default_nettype none
module serdes_link_lock_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import serdes_link_pkg::*;
  // short training minimum keeps the run small
  localparam int unsigned TMIN = 8;
  localparam logic [11:0] RA[5] = '{CTRL_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS, TX_WORD_OFS, 12'h018};
  localparam int HOLD[2] = '{1920, 200};
  // requested words plus TMIN-1 trailing words
  localparam int LO[2] = '{26, 8};
  localparam int HI[2] = '{28, 11};
  logic        clk, resetn, irq, train_a, train_b, ref_clk, ref_run, sleep_n, oe, tie;
  logic [1:0]  ref_div = 2'h0;
  logic        ser_out, tx_clk, p_ser, p_clk, p_en, p_bad, err;
  logic        lock_n, pw_oe_n, rc, rc_oe_n;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [9:0]  p_word;
  logic [9:0]  pw;
  logic [15:0] frames;
  logic [11:0] sh;
  logic [31:0] rd;
  int          n_fail, compares, ntr, ndat;
  // ==========================================
  // clocks, far end and design
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // slow enough for the pin filter to see every level
  always @(posedge clk)
  begin
    ref_div <= ref_div + 2'h1;
    if (ref_run && ref_div == 2'h3) ref_clk <= ~ref_clk;
  end
  // frames are told apart by their unique 12-bit windows
  always @(posedge tx_clk)
  begin
    sh = {sh[10:0], ser_out};
    if (sh === 12'h83e) ntr++;
    if (sh === 12'hfc0) ndat++;
  end
  serdes_far_tx_model far (
    .en     (p_en),
    .word   (p_word),
    .bad    (p_bad),
    .ser    (p_ser),
    .lclk   (p_clk),
    .frames (frames)
  );
  serdes_link_lock_control #(.TRAIN_MIN(TMIN)) dut (
    .clk                   (clk),
    .resetn                (resetn),
    .apb_req               (req),
    .apb_rsp               (rsp),
    .irq                   (irq),
    .training_request_a    (train_a),
    .training_request_b    (train_b | (tie & lock_n)),
    .local_reference_clock (ref_clk),
    .sleep_request_n       (sleep_n),
    .out_enable            (oe),
    .serial_out            (ser_out),
    .tx_link_clk           (tx_clk),
    .serial_in             (p_ser),
    .rx_link_clk           (p_clk),
    .lock_n                (lock_n),
    .parallel_word_out     (pw),
    .parallel_word_oe_n    (pw_oe_n),
    .recovered_clock       (rc),
    .recovered_clock_oe_n  (rc_oe_n)
  );
  // ==========================================
  // tasks
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_val(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_val(what, exp, rd);
  endtask
  // bounded wait on the lock indicator
  task automatic wait_lock(input logic v, input int n);
    for (int i = 0; i < n && lock_n !== v; i++) @(posedge clk);
    chk_bit("lock_n", v, lock_n);
  endtask
  task automatic frames_wait(input int n);
    repeat (n) @(frames);
    @(posedge clk);
  endtask
  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #1ms;
    n_fail++;
    complete_run();
  end
  // ==========================================
  // tests
  initial
  begin
    req = '0;
    {resetn, train_a, train_b, ref_clk, sleep_n, oe, p_en, p_bad, tie} = '0;
    ref_run = 1'b1;
    p_word = 10'h3e0;
    {n_fail, compares, ntr, ndat} = '0;
    sh = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    chk_bit("lock_n", 1'b1, lock_n);
    chk_bit("word_oe_n", 1'b1, pw_oe_n);
    for (int i = 0; i < 5; i++) rdchk("reset_value", RA[i], 32'h0);
    chk_bit("pslverr", 1'b1, err);
    $display("test reset done");
    sleep_n <= 1'b1;
    oe <= 1'b1;
    p_en <= 1'b1;
    wait_lock(1'b0, 3000);
    repeat (8) @(posedge clk);
    chk_bit("word_oe_n", 1'b0, pw_oe_n);
    chk_bit("clock_oe_n", 1'b0, rc_oe_n);
    chk_val("word", 32'h3e0, {22'h0, pw});
    rdchk("rx_word", RX_WORD_OFS, 32'h3e0);
    rdchk("irq_status", IRQ_STATUS_OFS, 32'h1);
    chk_bit("irq", 1'b0, irq);
    apb(1'b1, IRQ_MASK_OFS, 32'h7);
    repeat (2) @(posedge clk);
    chk_bit("irq", 1'b1, irq);
    apb(1'b1, IRQ_STATUS_OFS, 32'h7);
    repeat (2) @(posedge clk);
    chk_bit("irq", 1'b0, irq);
    $display("test lock done");
    p_word <= 10'h3c0;
    frames_wait(3);
    repeat (10) @(posedge clk);
    chk_val("word", 32'h3c0, {22'h0, pw});
    p_bad <= 1'b1;
    frames_wait(3);
    p_bad <= 1'b0;
    frames_wait(6);
    chk_bit("lock_n", 1'b0, lock_n);
    rdchk("irq_status", IRQ_STATUS_OFS, 32'h4);
    apb(1'b1, IRQ_STATUS_OFS, 32'h7);
    p_bad <= 1'b1;
    frames_wait(3);
    repeat (10) @(posedge clk);
    chk_bit("lock_n", 1'b0, lock_n);
    frames_wait(2);
    p_bad <= 1'b0;
    wait_lock(1'b1, 20);
    rdchk("irq_status", IRQ_STATUS_OFS, 32'h6);
    chk_bit("irq", 1'b1, irq);
    wait_lock(1'b0, 3000);
    repeat (10) @(posedge clk);
    chk_val("word", 32'h3c0, {22'h0, pw});
    $display("test loss done");
    oe <= 1'b0;
    repeat (8) @(posedge clk);
    chk_bit("word_oe_n", 1'b1, pw_oe_n);
    chk_bit("clock_oe_n", 1'b1, rc_oe_n);
    oe <= 1'b1;
    repeat (8) @(posedge clk);
    chk_bit("word_oe_n", 1'b0, pw_oe_n);
    tie <= 1'b1;
    sleep_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk_bit("lock_n", 1'b1, lock_n);
    chk_bit("word_oe_n", 1'b1, pw_oe_n);
    sleep_n <= 1'b1;
    repeat (20) @(posedge clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk_bit("training", 1'b1, rd[ST_TRAINING_POS]);
    wait_lock(1'b0, 3000);
    tie <= 1'b0;
    repeat (8) @(posedge clk);
    chk_bit("word_oe_n", 1'b0, pw_oe_n);
    ref_run <= 1'b0;
    wait_lock(1'b1, 200);
    ref_run <= 1'b1;
    wait_lock(1'b0, 3000);
    $display("test enable sleep done");
    apb(1'b1, TX_WORD_OFS, 32'h3e0);
    rdchk("tx_word", TX_WORD_OFS, 32'h3e0);
    for (int k = 0; k < 2; k++)
    begin
      repeat (200) @(posedge clk);
      ntr = 0;
      ndat = 0;
      if (k == 0) train_a <= 1'b1;
      else train_b <= 1'b1;
      repeat (HOLD[k]) @(posedge clk);
      train_a <= 1'b0;
      train_b <= 1'b0;
      repeat (1500) @(posedge clk);
      chk_bit("train_count", 1'b1, ntr >= LO[k] && ntr <= HI[k]);
      chk_bit("data_frames", 1'b1, ndat > 0);
    end
    $display("test training done");
    complete_run();
  end
endmodule // serdes_link_lock_control_tb_top
`default_nettype wire
